// File: src/ccou_channel.sv
module ccou_channel
  import ccou_pkg::*;
#(
  parameter bit IS_PERIOD_CHANNEL = 1'b0
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rd_data_out,
  input wire logic timer_tick_in,
  input wire logic [1:0] count_mode_in,
  input wire logic [DW-1:0] timer_count_in,
  input wire logic [DW-1:0] period_register_in,
  input wire logic global_irq_enable_in,
  input wire logic capture_input_a_in,
  input wire logic capture_input_b_in,
  output logic channel_output_out,
  output logic channel_equal_out,
  output logic irq_request_out
);

  // ****************************************
  // State
  // ****************************************
  ccou_state_s s;
  ccou_state_s next_s;
  ccou_bus_s bus;
  ccou_timer_s tmr;
  ccou_ctrl_s wctrl;
  logic cci_raw;
  logic cci_now;
  logic rise;
  logic fall;
  logic edge_hit;
  logic cap_fire;
  logic cmp_event;
  logic eq_x;
  logic eq_0;
  logic d_out;

  assign bus = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wr_data_in};
  assign tmr = '{tick: timer_tick_in,
                 mode: ccou_cmode_e'(count_mode_in),
                 count: timer_count_in,
                 period: period_register_in};
  assign wctrl = ccou_ctrl_s'(bus.wdata);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rdata = '0;

    // Pin inputs, two flops before use
    next_s.a_meta = capture_input_a_in;
    next_s.a_sync = s.a_meta;
    next_s.b_meta = capture_input_b_in;
    next_s.b_sync = s.b_meta;

    // Ground and supply selections let software drive the input
    case (s.ctrl.input_select)
      SEL_A: cci_raw = s.a_sync;
      SEL_B: cci_raw = s.b_sync;
      SEL_GND: cci_raw = 1'b0;
      SEL_VCC: cci_raw = 1'b1;
      default: cci_raw = 1'b0;
    endcase
    next_s.ctrl.capture_input = cci_raw;

    // Timed copy only moves on the timer edge, avoiding count races
    if (tmr.tick) begin
      next_s.cci_timed = cci_raw;
    end
    cci_now = s.ctrl.capture_sync_bit ? s.cci_timed : cci_raw;
    next_s.cci_prev = cci_now;
    rise = cci_now & ~s.cci_prev;
    fall = ~cci_now & s.cci_prev;

    case (s.ctrl.edge_mode)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
    cap_fire = s.ctrl.capture_select_bit & edge_hit;

    // Value equality, or count at least data on the period channel, so it fires counting up or down
    if (IS_PERIOD_CHANNEL) begin
      eq_x = tmr.count >= s.data;
    end else begin
      eq_x = tmr.count == s.data;
    end
    if (tmr.mode == CNT_UP) begin
      eq_0 = tmr.count == COUNT_ZERO;
    end else begin
      eq_0 = tmr.count >= tmr.period;
    end

    // Sample while the timer clock is low; hold across its edge
    if (!tmr.tick) begin
      next_s.eqx_s = eq_x;
      next_s.eq0_s = eq_0;
    end

    cmp_event = ~s.ctrl.capture_select_bit & tmr.tick & s.eqx_s;

    // Output control block
    case (s.ctrl.output_mode_field)
      OM_BITVAL: d_out = s.ctrl.output_value_bit;
      OM_SET: d_out = s.eqx_s ? 1'b1 : s.out;
      OM_TOG_RST: begin
        if (s.eqx_s && s.eq0_s) begin
          d_out = 1'b1;
        end else if (s.eq0_s) begin
          d_out = 1'b0;
        end else begin
          d_out = s.eqx_s ? ~s.out : s.out;
        end
      end
      OM_SET_RST: begin
        if (s.eqx_s) begin
          d_out = 1'b1;
        end else begin
          d_out = s.eq0_s ? 1'b0 : s.out;
        end
      end
      OM_TOGGLE: d_out = s.eqx_s ? ~s.out : s.out;
      OM_RESET: d_out = s.eqx_s ? 1'b0 : s.out;
      OM_TOG_SET: begin
        if (s.eqx_s && s.eq0_s) begin
          d_out = 1'b0;
        end else if (s.eq0_s) begin
          d_out = 1'b1;
        end else begin
          d_out = s.eqx_s ? ~s.out : s.out;
        end
      end
      OM_RST_SET: begin
        if (s.eqx_s) begin
          d_out = 1'b0;
        end else begin
          d_out = s.eq0_s ? 1'b1 : s.out;
        end
      end
      default: d_out = s.out;
    endcase
    if (tmr.tick) begin
      next_s.out = d_out;
    end

    // Register writes
    if (bus.wr && bus.addr == CTRL_ADDR) begin
      next_s.ctrl.edge_mode = wctrl.edge_mode;
      next_s.ctrl.input_select = wctrl.input_select;
      next_s.ctrl.capture_sync_bit = wctrl.capture_sync_bit;
      next_s.ctrl.capture_select_bit = wctrl.capture_select_bit;
      next_s.ctrl.output_mode_field = wctrl.output_mode_field;
      next_s.ctrl.channel_irq_enable = wctrl.channel_irq_enable;
      next_s.ctrl.output_value_bit = wctrl.output_value_bit;
      next_s.ctrl.channel_irq_flag = wctrl.channel_irq_flag;
      // Writing a one leaves the overflow flag alone
      next_s.ctrl.capture_overflow_flag =
        s.ctrl.capture_overflow_flag & wctrl.capture_overflow_flag;
    end
    if (bus.wr && bus.addr == DATA_ADDR) begin
      next_s.data = bus.wdata;
    end

    // Mode 0 bypasses the timer edge
    if (next_s.ctrl.output_mode_field == OM_BITVAL) begin
      next_s.out = next_s.ctrl.output_value_bit;
    end

    // Reads; a data read marks the captured value as taken
    if (bus.rd) begin
      case (bus.addr)
        CTRL_ADDR: next_s.rdata = s.ctrl;
        DATA_ADDR: begin
          next_s.rdata = s.data;
          next_s.unread = 1'b0;
        end
        default: next_s.rdata = '0;
      endcase
    end

    // Hardware sets last so they win over a clear in the same cycle
    if (cap_fire) begin
      next_s.data = tmr.count;
      next_s.ctrl.channel_irq_flag = 1'b1;
      next_s.unread = 1'b1;
      if (s.unread) begin
        next_s.ctrl.capture_overflow_flag = 1'b1;
      end
    end
    if (cmp_event) begin
      next_s.ctrl.channel_irq_flag = 1'b1;
    end

    next_s.irq = next_s.ctrl.channel_irq_flag &
                 next_s.ctrl.channel_irq_enable &
                 global_irq_enable_in;
    next_s.ctrl.reserved = '0;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_out = s.rdata;
  assign channel_output_out = s.out;
  assign channel_equal_out = s.eqx_s;
  assign irq_request_out = s.irq;

  // ****************************************
  // Checks
  // ****************************************
  a_ovf_sticky: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    s.ctrl.capture_overflow_flag &&
    !(bus.wr && bus.addr == CTRL_ADDR && !wctrl.capture_overflow_flag)
    |=> s.ctrl.capture_overflow_flag)
    else $error("overflow flag dropped without a write");

  a_cmp_no_capture: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !s.ctrl.capture_select_bit && !(bus.wr && bus.addr == DATA_ADDR)
    |=> $stable(s.data) && !$rose(s.ctrl.capture_overflow_flag))
    else $error("capture activity in compare mode");

  a_cmp_flag_set: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !s.ctrl.capture_select_bit && tmr.tick && s.eqx_s
    |=> s.ctrl.channel_irq_flag)
    else $error("compare match did not set flag");

  a_irq_gate: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    irq_request_out |-> s.ctrl.channel_irq_flag &&
    s.ctrl.channel_irq_enable && $past(global_irq_enable_in))
    else $error("interrupt request without enables");

  a_out_on_tick: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !tmr.tick && s.ctrl.output_mode_field != OM_BITVAL &&
    !(bus.wr && bus.addr == CTRL_ADDR)
    |=> $stable(s.out))
    else $error("output moved without a timer edge");

  a_mode0_follow: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    bus.wr && bus.addr == CTRL_ADDR &&
    wctrl.output_mode_field == OM_BITVAL
    |=> channel_output_out == $past(wctrl.output_value_bit))
    else $error("mode 0 output did not follow bit");

  a_mode4_toggle: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && s.ctrl.output_mode_field == OM_TOGGLE &&
    !bus.wr
    |=> s.out != $past(s.out))
    else $error("mode 4 did not toggle");

  a_mode5_clear: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && s.ctrl.output_mode_field == OM_RESET &&
    !bus.wr
    |=> !s.out ##1 (!s.out || bus.wr || $past(bus.wr)))
    else $error("mode 5 did not clear output");

  a_both_equal: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && s.eq0_s && !bus.wr &&
    s.ctrl.output_mode_field inside {OM_TOG_RST, OM_SET_RST}
    |=> s.out)
    else $error("both equal did not set output");

  a_capture_copy: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    cap_fire |=> s.data == $past(tmr.count) && s.ctrl.channel_irq_flag)
    else $error("capture did not copy count");

  a_ovf_second: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    cap_fire && s.unread |=> s.ctrl.capture_overflow_flag)
    else $error("lost capture not flagged");

  a_mode1_set: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && s.ctrl.output_mode_field == OM_SET && !bus.wr
    |=> s.out)
    else $error("mode 1 did not set output");

  a_mode2_toggle: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && !s.eq0_s && !bus.wr &&
    s.ctrl.output_mode_field == OM_TOG_RST
    |=> s.out != $past(s.out))
    else $error("mode 2 did not toggle");

  a_mode3_period: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && !s.eqx_s && s.eq0_s && !bus.wr &&
    s.ctrl.output_mode_field == OM_SET_RST
    |=> !s.out)
    else $error("mode 3 did not clear on period");

  a_mode6_period: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && !s.eqx_s && s.eq0_s && !bus.wr &&
    s.ctrl.output_mode_field == OM_TOG_SET
    |=> s.out)
    else $error("mode 6 did not set on period");

  a_mode7_clear: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && !bus.wr &&
    s.ctrl.output_mode_field == OM_RST_SET
    |=> !s.out)
    else $error("mode 7 did not clear on equal");

  a_both_low: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick && s.eqx_s && s.eq0_s && !bus.wr &&
    s.ctrl.output_mode_field inside {OM_TOG_SET, OM_RST_SET}
    |=> !s.out)
    else $error("both equal did not clear output");

  a_eq_hold: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    tmr.tick |=> $stable(s.eqx_s) && $stable(s.eq0_s))
    else $error("equal samples moved at timer edge");

  a_up_zero: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !tmr.tick && tmr.mode == CNT_UP
    |=> s.eq0_s == ($past(tmr.count) == COUNT_ZERO))
    else $error("up mode period equal not at zero");

  a_period_eq: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !tmr.tick && tmr.mode != CNT_UP
    |=> s.eq0_s == ($past(tmr.count) >= $past(tmr.period)))
    else $error("period equal not count at least period");

  a_sync_hold: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    !tmr.tick |=> $stable(s.cci_timed))
    else $error("timed capture input moved without tick");

endmodule

// File: src/ccou_pkg.sv
package ccou_pkg;

  // ****************************************
  // Widths and register addresses
  // ****************************************
  localparam int DW = 16;
  localparam int AW = 2;
  localparam logic [AW-1:0] CTRL_ADDR = 2'h0;
  localparam logic [AW-1:0] DATA_ADDR = 2'h1;
  localparam logic [DW-1:0] COUNT_ZERO = 16'h0000;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [2:0] {
    OM_BITVAL = 3'h0,
    OM_SET = 3'h1,
    OM_TOG_RST = 3'h2,
    OM_SET_RST = 3'h3,
    OM_TOGGLE = 3'h4,
    OM_RESET = 3'h5,
    OM_TOG_SET = 3'h6,
    OM_RST_SET = 3'h7
  } ccou_omode_e;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } ccou_edge_e;

  typedef enum logic [1:0] {
    SEL_A = 2'h0,
    SEL_B = 2'h1,
    SEL_GND = 2'h2,
    SEL_VCC = 2'h3
  } ccou_insel_e;

  typedef enum logic [1:0] {
    CNT_STOP = 2'h0,
    CNT_UP = 2'h1,
    CNT_CONT = 2'h2,
    CNT_UPDN = 2'h3
  } ccou_cmode_e;

  // ****************************************
  // Channel control register layout, msb first
  // ****************************************
  typedef struct packed {
    ccou_edge_e edge_mode;
    ccou_insel_e input_select;
    logic capture_sync_bit;
    logic [1:0] reserved;
    logic capture_select_bit;
    ccou_omode_e output_mode_field;
    logic channel_irq_enable;
    logic capture_input;
    logic output_value_bit;
    logic capture_overflow_flag;
    logic channel_irq_flag;
  } ccou_ctrl_s;

  localparam ccou_ctrl_s CTRL_RESET = '0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ccou_bus_s;

  typedef struct packed {
    logic tick;
    ccou_cmode_e mode;
    logic [DW-1:0] count;
    logic [DW-1:0] period;
  } ccou_timer_s;

  typedef struct packed {
    ccou_ctrl_s ctrl;
    logic [DW-1:0] data;
    logic unread;
    logic out;
    logic irq;
    logic [DW-1:0] rdata;
    logic a_meta;
    logic a_sync;
    logic b_meta;
    logic b_sync;
    logic cci_timed;
    logic cci_prev;
    logic eqx_s;
    logic eq0_s;
  } ccou_state_s;

  localparam ccou_state_s STATE_RESET = '0;

endpackage

// File: test/ccou_channel_tb.sv
module ccou_channel_tb
  import ccou_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic global_irq_enable = 1'b0;
  wire tick, pa, pb, out, eq, irq;
  ccou_cmode_e cmode;
  wire [DW-1:0] cnt, per, rdata;
  int bad_count = 0;
  int total_checks = 0;
  logic [DW-1:0] v, pc;
  logic e0, ex, b;
  ccou_ctrl_s c;

  ccou_timer_model u_tmr (.mclk_in(mclk_in), .tick_out(tick),
    .mode_out(cmode), .count_out(cnt), .period_out(per),
    .pin_a_out(pa), .pin_b_out(pb));

  // Not the period channel, so all eight modes are usable
  ccou_channel #(.IS_PERIOD_CHANNEL(1'b0)) u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
    .timer_tick_in(tick), .count_mode_in(cmode), .timer_count_in(cnt),
    .period_register_in(per), .global_irq_enable_in(global_irq_enable),
    .capture_input_a_in(pa), .capture_input_b_in(pb),
    .channel_output_out(out), .channel_equal_out(eq),
    .irq_request_out(irq));

  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  // ****
  // Bus and check tasks
  // ****
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  function automatic logic nxt(int m, logic e0, logic ex, logic o);
    case (m)
      1: return ex ? 1'b1 : o;
      2: return e0 ? ex : (ex ? ~o : o);
      3: return e0 ? ex : (ex ? 1'b1 : o);
      4: return ex ? ~o : o;
      5: return ex ? 1'b0 : o;
      6: return e0 ? ~ex : (ex ? ~o : o);
      default: return e0 ? ~ex : (ex ? 1'b0 : o);
    endcase
  endfunction

  initial begin
    wait_cyc(5000);
    bad_count++;
    finish_test();
  end

  // ****
  // Tests
  // ****
  initial begin
    wait_cyc(6);
    reset_in <= 1'b0;
    rd_reg(CTRL_ADDR, v);
    chk("ctrl_reset", 16'h0000, v);
    chk("out_reset", 16'h0000, out);
    rd_reg(2'h2, v);
    chk("unmapped", 16'h0000, v);
    wr_reg(DATA_ADDR, 16'h0005);
    c = CTRL_RESET;
    c.channel_irq_enable = 1'b1;
    wr_reg(CTRL_ADDR, c);
    u_tmr.load(16'h0005, 16'h0009, CNT_CONT);
    u_tmr.tick_once();
    #1 chk("equal", 16'h0001, eq);
    chk("irq_no_gie", 16'h0000, irq);
    rd_reg(CTRL_ADDR, v);
    chk("cmp_flag", 16'h0001, v[0]);
    @(posedge mclk_in);
    global_irq_enable <= 1'b1;
    wait_cyc(2);
    #1 chk("irq_gie", 16'h0001, irq);
    c = CTRL_RESET;
    c.edge_mode = EDGE_BOTH;
    c.input_select = SEL_GND;
    wr_reg(CTRL_ADDR, c);
    c.input_select = SEL_VCC;
    wr_reg(CTRL_ADDR, c);
    wait_cyc(6);
    rd_reg(CTRL_ADDR, v);
    chk("cmp_nocap", 16'h0000, v[1:0]);
    for (int m = 1; m < 8; m++) begin
      for (int k = 0; k < 8; k++) begin
        e0 = k[0];
        ex = k[1];
        b = k[2];
        c = CTRL_RESET;
        c.output_value_bit = b;
        wr_reg(CTRL_ADDR, c);
        c.output_mode_field = ccou_omode_e'(m[2:0]);
        wr_reg(CTRL_ADDR, c);
        @(posedge mclk_in);
        #1 chk("out_hold", {15'h0, b}, out);
        pc = ex ? 16'h0005 : 16'h0006;
        u_tmr.load(pc, e0 ? pc : pc + 16'h1,
                   m[0] ? CNT_CONT : CNT_UPDN);
        u_tmr.tick_once();
        #1 chk("out_mode", {15'h0, nxt(m, e0, ex, b)}, out);
      end
    end
    c = CTRL_RESET;
    wr_reg(CTRL_ADDR, c);
    c.output_mode_field = OM_RST_SET;
    wr_reg(CTRL_ADDR, c);
    u_tmr.load(16'h0000, 16'h0009, CNT_UP);
    u_tmr.tick_once();
    #1 chk("out_up_zero", 16'h0001, out);
    u_tmr.load(16'h1234, 16'hffff, CNT_CONT);
    c = CTRL_RESET;
    c.capture_select_bit = 1'b1;
    c.edge_mode = EDGE_BOTH;
    c.input_select = SEL_GND;
    wr_reg(CTRL_ADDR, c);
    c.input_select = SEL_VCC;
    wr_reg(CTRL_ADDR, c);
    wait_cyc(6);
    rd_reg(DATA_ADDR, v);
    chk("sw_capture", 16'h1234, v);
    @(posedge mclk_in);
    #1 chk("rdata_idle", 16'h0000, rdata);
    rd_reg(CTRL_ADDR, v);
    chk("cap_flags", 16'h0001, v[1:0]);
    u_tmr.load(16'h2222, 16'hffff, CNT_CONT);
    c.input_select = SEL_GND;
    wr_reg(CTRL_ADDR, c);
    wait_cyc(6);
    c.input_select = SEL_VCC;
    wr_reg(CTRL_ADDR, c);
    wait_cyc(6);
    rd_reg(DATA_ADDR, v);
    rd_reg(CTRL_ADDR, v);
    chk("overflow", 16'h0001, v[1]);
    wr_reg(CTRL_ADDR, c);
    rd_reg(CTRL_ADDR, v);
    chk("ovf_clear", 16'h0000, v[1]);
    u_tmr.load(16'h0abc, 16'hffff, CNT_CONT);
    c.edge_mode = EDGE_RISE;
    c.input_select = SEL_A;
    wr_reg(CTRL_ADDR, c);
    u_tmr.pin_a(1'b1);
    wait_cyc(8);
    rd_reg(DATA_ADDR, v);
    chk("pin_capture", 16'h0abc, v);
    // Edge detect off while the sync path is switched in
    c.capture_sync_bit = 1'b1;
    c.edge_mode = EDGE_NONE;
    c.input_select = SEL_GND;
    wr_reg(CTRL_ADDR, c);
    c.edge_mode = EDGE_BOTH;
    c.input_select = SEL_VCC;
    wr_reg(CTRL_ADDR, c);
    wait_cyc(4);
    rd_reg(CTRL_ADDR, v);
    chk("sync_wait", 16'h0000, v[0]);
    u_tmr.load(16'h4444, 16'hffff, CNT_CONT);
    u_tmr.tick_once();
    wait_cyc(4);
    rd_reg(DATA_ADDR, v);
    chk("sync_capture", 16'h4444, v);
    u_tmr.pin_b(1'b1);
    wait_cyc(3);
    c.capture_sync_bit = 1'b0;
    c.edge_mode = EDGE_FALL;
    c.input_select = SEL_B;
    wr_reg(CTRL_ADDR, c);
    u_tmr.load(16'h5555, 16'hffff, CNT_CONT);
    u_tmr.pin_b(1'b0);
    wait_cyc(8);
    rd_reg(DATA_ADDR, v);
    chk("fall_capture", 16'h5555, v);
    finish_test();
  end
endmodule

// File: test/ccou_timer_model.sv
// ****
// Timer and capture pin side
// ****
module ccou_timer_model
  import ccou_pkg::*;
(
  input wire logic mclk_in,
  output logic tick_out,
  output ccou_cmode_e mode_out,
  output logic [DW-1:0] count_out,
  output logic [DW-1:0] period_out,
  output logic pin_a_out,
  output logic pin_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tick_out = 1'b0;
    mode_out = CNT_STOP;
    count_out = 16'h0000;
    period_out = 16'hffff;
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // Count settles a cycle before any tick
  task automatic load(input logic [DW-1:0] c, input logic [DW-1:0] p,
                      input ccou_cmode_e m);
    @(posedge mclk_in);
    count_out <= c;
    period_out <= p;
    mode_out <= m;
  endtask
  task automatic tick_once();
    @(posedge mclk_in);
    tick_out <= 1'b1;
    @(posedge mclk_in);
    tick_out <= 1'b0;
  endtask
  task automatic pin_a(input logic v);
    @(posedge mclk_in);
    pin_a_out <= v;
  endtask
  task automatic pin_b(input logic v);
    @(posedge mclk_in);
    pin_b_out <= v;
  endtask
endmodule
